// >>> hdl/gpio_irq_pkg.sv
// constants shared by the gpio and external interrupt pin block
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package gpio_irq_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int unsigned PIN_COUNT    = 16;
  localparam int unsigned EXT_COUNT    = 4;
  localparam int unsigned EXT_LSB      = 4;
  localparam int unsigned HIGH_LSB     = 9;
  localparam int unsigned HIGH_COUNT   = 7;
  localparam int unsigned STAT_WIDTH   = 9;
  localparam int unsigned SYNC_WIDTH   = 17;
  localparam int unsigned NMI_SYNC_BIT = 16;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFF_DIRECTION = 8'h00;
  localparam logic [7:0] OFF_OUT_DATA  = 8'h04;
  localparam logic [7:0] OFF_IN_DATA   = 8'h08;
  localparam logic [7:0] OFF_HIGH_EN   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h10;
  localparam logic [7:0] OFF_POLARITY  = 8'h14;
  localparam logic [7:0] OFF_PIN0_MODE = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  localparam logic [7:0] OFF_MASK      = 8'h20;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned STAT_EXT_LSB = 4;
  localparam int unsigned STAT_NMI_BIT = 8;
  localparam int unsigned HIGH_EN_LSB  = 9;
  localparam int unsigned MODE_WIDTH   = 2;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_OUT_DATA  = 16'h0000;
  localparam logic [6:0]  RST_HIGH_EN   = 7'h00;
  localparam logic [3:0]  RST_IRQ_EN    = 4'h0;
  localparam logic [3:0]  RST_POLARITY  = 4'h0;
  localparam logic [8:0]  RST_MASK      = 9'h000;
  localparam logic [8:0]  RST_STATUS    = 9'h000;

  // ***************************************************************
  // bus encodings
  // ***************************************************************
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    PIN0_INPUT,
    PIN0_OUTPUT,
    PIN0_IRQ_OUT
  } pin0_mode_t;

endpackage

// >>> hdl/edge_if.sv
// synchronised pin levels and their edge strobes between sync and core
// assumes both ends run on the same hclk
`timescale 1ns/10ps
interface edge_if #(
  parameter int unsigned W = 17
);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input  level, input  rise, input  fall);
endinterface

// >>> hdl/pin_edge_sync.sv
// two-flop synchroniser and edge detector for asynchronous pins
// assumes pins are asynchronous to hclk; edges held off until samples valid
`timescale 1ns/10ps
module pin_edge_sync #(
  parameter int unsigned W = 17
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] pins_async,
  edge_if.src               e
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;
  logic [1:0]   warm;
  logic         armed;

  // ***************************************************************
  // synchroniser, one per pin
  // ***************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i]   <= 1'b0;
          stable[i] <= 1'b0;
          prev[i]   <= 1'b0;
        end else begin
          meta[i]   <= pins_async[i];
          stable[i] <= meta[i];
          prev[i]   <= stable[i];
        end
      end
      // no edges until prev holds a real sample, so pulled-up pins
      // do not fake a rising edge just after reset
      assign e.rise[i] = armed & stable[i] & ~prev[i];
      assign e.fall[i] = armed & ~stable[i] & prev[i];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm  <= 2'h0;
      armed <= 1'b0;
    end else if (!armed) begin
      warm  <= warm + 2'h1;
      armed <= (warm == 2'h2);
    end
  end

  assign e.level = stable;

endmodule // pin_edge_sync

// >>> hdl/gpio_irq_pins.sv
// gpio port with edge-triggered external interrupts and nmi edge input
// assumes an ahb-lite master on hclk; pins asynchronous, pad logic outside
//
// Function
// R1: the nonmaskable interrupt fires on a rising edge of its pin, never on its level.
// R2: after reset the four shared pins 7..4 are inputs with their drivers off.
// R3: a shared pin acts as an edge interrupt only while its enable bit in bits 7..4 is set.
// R4: software picks each external interrupt's active edge in a four-bit polarity field 3..0.
// R5: pins 15..9 have no function enabled after reset until software enables them.
// R6: pin 0 is an input after reset and software may make it an output-only pin.
// R7: pin 0 may instead be set to drive the port interrupt signal out, output only.
// R8: polarity bit 0 belongs to the lowest shared interrupt pin and bit 3 to the highest.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module gpio_irq_pins (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  input  wire logic [15:0] general_purpose_port_in,
  output      logic [15:0] general_purpose_port_out,
  output      logic [15:0] general_purpose_port_oe,
  input  wire logic        nmi_pin,
  output      logic        nmi_event,
  output      logic [3:0]  external_irq_in,
  output      logic        port_irq_out
);

  localparam int unsigned NP = gpio_irq_pkg::PIN_COUNT;
  localparam int unsigned NE = gpio_irq_pkg::EXT_COUNT;
  localparam int unsigned NS = gpio_irq_pkg::STAT_WIDTH;
  localparam int unsigned NH = gpio_irq_pkg::HIGH_COUNT;

  // ***************************************************************
  // pin synchronisation and edge detection
  // ***************************************************************
  edge_if #(.W(gpio_irq_pkg::SYNC_WIDTH)) pin_edges ();

  logic [gpio_irq_pkg::SYNC_WIDTH-1:0] raw_pins;

  assign raw_pins = {nmi_pin, general_purpose_port_in};

  pin_edge_sync #(
    .W (gpio_irq_pkg::SYNC_WIDTH)
  ) u_sync (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pins_async (raw_pins),
    .e          (pin_edges)
  );

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [NP-1:0]            direction;
  logic [NP-1:0]            out_data;
  logic [NH-1:0]            high_en;
  logic [NE-1:0]            irq_enable_bits;
  logic [NE-1:0]            ext_irq_edge_polarity;
  gpio_irq_pkg::pin0_mode_t pin0_mode;
  logic [NS-1:0]            irq_status;
  logic [NS-1:0]            irq_mask;
  logic [NS-1:0]            next_irq_status;
  logic [NS-1:0]            event_bits;
  logic [NE-1:0]            ext_event;
  logic [NP-1:0]            in_view;
  logic [31:0]              next_hrdata;

  // ***************************************************************
  // ahb-lite slave
  // ***************************************************************
  logic       accept;
  logic       rd_accept;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       status_read;

  // zero wait state, always okay
  assign hreadyout   = 1'b1;
  assign hresp       = gpio_irq_pkg::HRESP_OKAY;
  assign accept      = hsel & hready & htrans[1];
  assign rd_accept   = accept & ~hwrite;
  assign status_read = rd_accept & (haddr[7:0] == gpio_irq_pkg::OFF_STATUS);

  // only whole-word writes are stored; narrower writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= accept & hwrite & (hsize == gpio_irq_pkg::HSIZE_WORD);
      wr_addr <= haddr[7:0];
    end
  end

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_pend & (wr_addr == off);
  endfunction

  // read data sampled at the address phase, so a read right after a
  // write to the same register returns the value before that write
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr[7:0] == gpio_irq_pkg::OFF_DIRECTION) begin
      next_hrdata[NP-1:0] = direction;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_OUT_DATA) begin
      next_hrdata[NP-1:0] = out_data;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_IN_DATA) begin
      next_hrdata[NP-1:0] = in_view;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_HIGH_EN) begin
      next_hrdata[gpio_irq_pkg::HIGH_EN_LSB +: NH] = high_en;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_IRQ_EN) begin
      next_hrdata[gpio_irq_pkg::EXT_LSB +: NE] = irq_enable_bits;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_POLARITY) begin
      next_hrdata[NE-1:0] = ext_irq_edge_polarity;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_PIN0_MODE) begin
      next_hrdata[gpio_irq_pkg::MODE_WIDTH-1:0] = pin0_mode;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_STATUS) begin
      next_hrdata[NS-1:0] = irq_status;
    end else if (haddr[7:0] == gpio_irq_pkg::OFF_MASK) begin
      next_hrdata[NS-1:0] = irq_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_accept) begin
      hrdata <= next_hrdata;
    end
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction <= gpio_irq_pkg::RST_DIRECTION; // R2
    end else if (wr_hit(gpio_irq_pkg::OFF_DIRECTION)) begin
      direction <= hwdata[NP-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data <= gpio_irq_pkg::RST_OUT_DATA;
    end else if (wr_hit(gpio_irq_pkg::OFF_OUT_DATA)) begin
      out_data <= hwdata[NP-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_en <= gpio_irq_pkg::RST_HIGH_EN; // R5
    end else if (wr_hit(gpio_irq_pkg::OFF_HIGH_EN)) begin
      high_en <= hwdata[gpio_irq_pkg::HIGH_EN_LSB +: NH];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_bits <= gpio_irq_pkg::RST_IRQ_EN;
    end else if (wr_hit(gpio_irq_pkg::OFF_IRQ_EN)) begin
      irq_enable_bits <= hwdata[gpio_irq_pkg::EXT_LSB +: NE]; // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_edge_polarity <= gpio_irq_pkg::RST_POLARITY;
    end else if (wr_hit(gpio_irq_pkg::OFF_POLARITY)) begin
      ext_irq_edge_polarity <= hwdata[NE-1:0]; // R4
    end
  end

  // code 3 is not a mode; such a write leaves the mode as it was
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin0_mode <= gpio_irq_pkg::PIN0_INPUT; // R6
    end else if (wr_hit(gpio_irq_pkg::OFF_PIN0_MODE)) begin
      case (hwdata[gpio_irq_pkg::MODE_WIDTH-1:0])
        2'h0:    pin0_mode <= gpio_irq_pkg::PIN0_INPUT;
        2'h1:    pin0_mode <= gpio_irq_pkg::PIN0_OUTPUT; // R6
        2'h2:    pin0_mode <= gpio_irq_pkg::PIN0_IRQ_OUT; // R7
        default: pin0_mode <= pin0_mode;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= gpio_irq_pkg::RST_MASK;
    end else if (wr_hit(gpio_irq_pkg::OFF_MASK)) begin
      irq_mask <= hwdata[NS-1:0];
    end
  end

  // ***************************************************************
  // external interrupts and nmi
  // ***************************************************************
  genvar k;
  generate
    for (k = 0; k < NE; k++) begin : g_ext
      // polarity bit k steers pin EXT_LSB+k; 0 rising, 1 falling
      assign ext_event[k] = irq_enable_bits[k] &                       // R3
                            (ext_irq_edge_polarity[k] ?                // R8
                             pin_edges.fall[gpio_irq_pkg::EXT_LSB + k] :
                             pin_edges.rise[gpio_irq_pkg::EXT_LSB + k]); // R4
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      external_irq_in <= 4'h0;
    end else begin
      external_irq_in <= ext_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_event <= 1'b0;
    end else begin
      // a high level alone never fires, only the low-to-high change
      nmi_event <= pin_edges.rise[gpio_irq_pkg::NMI_SYNC_BIT]; // R1
    end
  end

  always_comb begin
    event_bits = '0;
    event_bits[gpio_irq_pkg::STAT_EXT_LSB +: NE] = ext_event;
    event_bits[gpio_irq_pkg::STAT_NMI_BIT] = pin_edges.rise[gpio_irq_pkg::NMI_SYNC_BIT]; // R1
  end

  // an event in the cycle of the clearing read survives the clear
  always_comb begin
    next_irq_status = irq_status;
    if (status_read) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | event_bits;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= gpio_irq_pkg::RST_STATUS;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_irq_out <= 1'b0;
    end else begin
      port_irq_out <= |(next_irq_status & irq_mask);
    end
  end

  // ***************************************************************
  // pad control
  // ***************************************************************
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pad
      if (p == 0) begin : g_pin0
        // pin 0 is input only or output only, never both
        assign general_purpose_port_oe[p]  = (pin0_mode != gpio_irq_pkg::PIN0_INPUT); // R6
        assign general_purpose_port_out[p] = (pin0_mode == gpio_irq_pkg::PIN0_IRQ_OUT) ?
                                             port_irq_out : out_data[p]; // R7
        assign in_view[p] = (pin0_mode == gpio_irq_pkg::PIN0_INPUT) & pin_edges.level[p];
      end else if (p >= gpio_irq_pkg::EXT_LSB && p < gpio_irq_pkg::EXT_LSB + NE) begin : g_ext
        // interrupt use forces the pin to input
        assign general_purpose_port_oe[p]  = direction[p] &
                                             ~irq_enable_bits[p - gpio_irq_pkg::EXT_LSB]; // R2
        assign general_purpose_port_out[p] = out_data[p];
        assign in_view[p] = pin_edges.level[p];
      end else if (p >= gpio_irq_pkg::HIGH_LSB) begin : g_high
        // disabled pins neither drive nor report
        assign general_purpose_port_oe[p]  = direction[p] &
                                             high_en[p - gpio_irq_pkg::HIGH_LSB]; // R5
        assign general_purpose_port_out[p] = out_data[p];
        assign in_view[p] = high_en[p - gpio_irq_pkg::HIGH_LSB] & pin_edges.level[p]; // R5
      end else begin : g_plain
        assign general_purpose_port_oe[p]  = direction[p];
        assign general_purpose_port_out[p] = out_data[p];
        assign in_view[p] = pin_edges.level[p];
      end
    end
  endgenerate

endmodule // gpio_irq_pins

// >>> testbench/gpio_irq_pins_monitor.sv
// concurrent checks on the top ports of the gpio and interrupt pin block
// assumes one hclk domain and the async active-low hresetn
`timescale 1ns/10ps
module gpio_irq_pins_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [15:0] general_purpose_port_in,
  input wire logic [15:0] general_purpose_port_out,
  input wire logic [15:0] general_purpose_port_oe,
  input wire logic        nmi_pin,
  input wire logic        nmi_event,
  input wire logic [3:0]  external_irq_in,
  input wire logic        port_irq_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [3:0] since_nmi;
  logic [3:0] since_ext;

  // ****
  // cycles since the last cause; saturates so a held level looks old
  // ****
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      since_nmi <= 4'hF;
    else if ($rose(nmi_pin))
      since_nmi <= 4'h0;
    else if (since_nmi != 4'hF)
      since_nmi <= since_nmi + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      since_ext <= 4'hF;
    else if ($changed(general_purpose_port_in[7:4]))
      since_ext <= 4'h0;
    else if (since_ext != 4'hF)
      since_ext <= since_ext + 4'h1;
  end

  property p_nmi_rise;
    $rose(nmi_pin) |-> ##[1:5] nmi_event;
  endproperty
  a_nmi_rise: assert property (p_nmi_rise) else $error("nmi edge gave no event");

  property p_nmi_pulse;
    nmi_event |=> !nmi_event;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi event longer than one cycle");

  property p_nmi_cause;
    nmi_event |-> since_nmi <= 4'h5;
  endproperty
  a_nmi_cause: assert property (p_nmi_cause) else $error("nmi event without a rising edge");

  property p_ext_cause;
    (external_irq_in != 4'h0) |-> since_ext <= 4'h5;
  endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("external event without pin edge");

  property p_ext_pulse;
    (external_irq_in != 4'h0) |=> (external_irq_in & $past(external_irq_in)) == 4'h0;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("external event held too long");

  property p_reset_oe;
    $rose(hresetn) |-> general_purpose_port_oe == 16'h0000;
  endproperty
  a_reset_oe: assert property (p_reset_oe) else $error("pin driver on after reset");

  property p_reset_out;
    $rose(hresetn) |-> general_purpose_port_out == 16'h0000 && !port_irq_out;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output not quiet after reset");

  property p_irq_cause;
    $rose(port_irq_out) |-> nmi_event || external_irq_in != 4'h0 || $past(hsel)
      || $past(hsel, 2) || $past(hsel, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("port interrupt rose unprompted");

  c_nmi: cover property (nmi_event);
  c_ext: cover property (external_irq_in != 4'h0);
  c_irq: cover property ($rose(port_irq_out));
endmodule // gpio_irq_pins_monitor

bind gpio_irq_pins gpio_irq_pins_monitor gpio_irq_pins_monitor_i (
  .hclk, .hresetn, .hsel, .general_purpose_port_in, .general_purpose_port_out,
  .general_purpose_port_oe, .nmi_pin, .nmi_event, .external_irq_in, .port_irq_out
);

// >>> testbench/board_pins_model.sv
// board side of the gpio pins: pulls, external drivers, floating lines
// assumes the device driver wins over the board driver on every pin
`timescale 1ns/10ps
module board_pins_model (
  input  wire logic        hclk,
  input  wire logic [15:0] dev_out,
  input  wire logic [15:0] dev_oe,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  input  wire logic        nmi_drive,
  output      logic [15:0] pins,
  output      logic        nmi_pin
);
  localparam logic [15:0] PULL_UP   = 16'h00F0;
  localparam logic [15:0] PULL_MASK = 16'h01FF;
  logic [15:0] float_val = 16'h5555;

  // unpulled lines wander so a stale level is never mistaken for data
  always_ff @(posedge hclk) begin
    float_val <= ~pins;
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (dev_oe[i])
        pins[i] = dev_out[i];
      else if (ext_en[i])
        pins[i] = ext_val[i];
      else if (PULL_MASK[i])
        pins[i] = PULL_UP[i];
      else
        pins[i] = float_val[i];
    end
  end

  // nmi line driven straight from nmi_drive by the bench, never left floating
  assign nmi_pin = nmi_drive;
endmodule // board_pins_model

// >>> testbench/tb_gpio_irq_pins.sv
// self-checking bench: ahb-lite register access plus pin stimulus
// assumes zero-wait slave and the board model on the pin side
`timescale 1ns/10ps
module tb_gpio_irq_pins;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = gpio_irq_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h00000000;
  logic        hreadyout, hresp, nmi_pin, nmi_event, port_irq_out;
  logic [31:0] hrdata, rdat;
  logic [15:0] pins, gp_out, gp_oe;
  logic [15:0] pin_drive = 16'hA5A5;
  logic        nmi_drive = 1'b0;
  logic [3:0]  ext_irq;
  logic [4:0]  seen = 5'h00;
  int          failures = 0;
  int          n_compared = 0;

  always #5 hclk = ~hclk;

  // sticky record of event pulses; gated so unreset outputs cannot poison it
  always @(posedge hclk) if (hresetn) seen <= seen | {nmi_event, ext_irq};

  gpio_irq_pins gpio_irq_pins_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .general_purpose_port_in(pins), .general_purpose_port_out(gp_out),
    .general_purpose_port_oe(gp_oe), .nmi_pin, .nmi_event, .external_irq_in(ext_irq),
    .port_irq_out);

  board_pins_model board_pins_model_i (.hclk, .dev_out(gp_out), .dev_oe(gp_oe),
    .ext_val(pin_drive), .ext_en(16'hFFFF), .nmi_drive, .pins, .nmi_pin);

  // ****
  // bus and compare tasks
  // ****
  task automatic conclude;
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rdat = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000);
    chk(nm, exp, rdat);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  initial begin
    #200000;
    failures++;
    conclude();
  end

  // ****
  // test sequence
  // ****
  initial begin
    idle(5);
    hresetn <= 1'b1;
    idle(6);
    @(negedge hclk);
    chk("oe", 32'h0, {16'h0, gp_oe});
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
    rchk("dir", gpio_irq_pkg::OFF_DIRECTION, 32'h0);
    rchk("irq_en", gpio_irq_pkg::OFF_IRQ_EN, 32'h0);
    rchk("pol", gpio_irq_pkg::OFF_POLARITY, 32'h0);
    rchk("high_en", gpio_irq_pkg::OFF_HIGH_EN, 32'h0);
    rchk("mode", gpio_irq_pkg::OFF_PIN0_MODE, 32'h0);
    rchk("in", gpio_irq_pkg::OFF_IN_DATA, 32'h000001A5);
    rchk("unmapped", 8'h40, 32'h0);
    pin_drive[4] <= 1'b1;
    idle(8);
    rchk("disabled", gpio_irq_pkg::OFF_STATUS, 32'h0);
    xfer(gpio_irq_pkg::OFF_HIGH_EN, 1'b1, 32'h0000FE00);
    rchk("in_high", gpio_irq_pkg::OFF_IN_DATA, 32'h0000A5B5);
    xfer(gpio_irq_pkg::OFF_DIRECTION, 1'b1, 32'h0000FE00);
    xfer(gpio_irq_pkg::OFF_PIN0_MODE, 1'b1, 32'h1);
    xfer(gpio_irq_pkg::OFF_OUT_DATA, 1'b1, 32'h00005A01);
    @(negedge hclk);
    chk("oe_out", 32'hFE015A01, {gp_oe, gp_out});
    // driven levels need two sync flops before the input view shows them
    idle(3);
    rchk("in_out", gpio_irq_pkg::OFF_IN_DATA, 32'h00005BB4);
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 2; p++) begin
        pin_drive[4 + k] <= p[0];
        idle(8);
        xfer(gpio_irq_pkg::OFF_POLARITY, 1'b1, 32'(p) << k);
        xfer(gpio_irq_pkg::OFF_IRQ_EN, 1'b1, 32'h1 << (4 + k));
        xfer(gpio_irq_pkg::OFF_MASK, 1'b1, 32'h1 << (4 + k));
        xfer(gpio_irq_pkg::OFF_STATUS, 1'b0, 32'h0);
        pin_drive[4 + k] <= ~p[0];
        idle(8);
        @(negedge hclk);
        chk("irq_set", 32'h1, {31'h0, port_irq_out});
        @(posedge hclk);
        rchk("status", gpio_irq_pkg::OFF_STATUS, 32'h1 << (4 + k));
        @(negedge hclk);
        chk("irq_clr", 32'h0, {31'h0, port_irq_out});
        @(posedge hclk);
        pin_drive[4 + k] <= p[0];
        idle(8);
        rchk("wrong_edge", gpio_irq_pkg::OFF_STATUS, 32'h0);
      end
    end
    chk("ext_seen", 32'h0F, {27'h0, seen});
    xfer(gpio_irq_pkg::OFF_MASK, 1'b1, 32'h0);
    nmi_drive <= 1'b1;
    idle(8);
    @(negedge hclk);
    chk("masked", 32'h0, {31'h0, port_irq_out});
    @(posedge hclk);
    rchk("nmi", gpio_irq_pkg::OFF_STATUS, 32'h100);
    idle(8);
    rchk("nmi_level", gpio_irq_pkg::OFF_STATUS, 32'h0);
    nmi_drive <= 1'b0;
    xfer(gpio_irq_pkg::OFF_PIN0_MODE, 1'b1, 32'h2);
    xfer(gpio_irq_pkg::OFF_MASK, 1'b1, 32'h100);
    idle(6);
    @(negedge hclk);
    chk("pin0_low", 32'h10000, {15'h0, gp_oe[0], 15'h0, gp_out[0]});
    @(posedge hclk);
    nmi_drive <= 1'b1;
    idle(8);
    @(negedge hclk);
    chk("pin0_irq", 32'h1, {31'h0, gp_out[0]});
    @(posedge hclk);
    xfer(gpio_irq_pkg::OFF_STATUS, 1'b0, 32'h0);
    @(negedge hclk);
    chk("pin0_clr", 32'h0, {31'h0, gp_out[0]});
    chk("nmi_seen", 32'h1F, {27'h0, seen});
    conclude();
  end
endmodule // tb_gpio_irq_pins
